// ===== geo_param_pkg.sv
// geo_param_pkg: shared constants and types of the parameter stream decoder.
// Assumes both ends of the 64-bit parameter link import it.
package geo_param_pkg;

  // ----------------------------------------------------------------------
  // link word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W    = 64;
  localparam int unsigned ITEM_W    = 32;
  localparam int unsigned LO_ITEM_L = 0;   // lower byte offset item
  localparam int unsigned HI_ITEM_L = 32;  // next byte offset item

  // ----------------------------------------------------------------------
  // record length in link words
  // ----------------------------------------------------------------------
  localparam logic [2:0] LAST_BEAT_32B = 3'h3;  // 32-byte record: beats 0..3
  localparam logic [2:0] LAST_BEAT_64B = 3'h7;  // 64-byte record: beats 0..7
  localparam int unsigned REC_WORDS    = 8;

  // ----------------------------------------------------------------------
  // exact control words
  // ----------------------------------------------------------------------
  localparam logic [31:0] CW_END_LIST = 32'h0000_0000;
  localparam logic [31:0] CW_TILE_CLIP = 32'h2000_0000;
  localparam logic [31:0] CW_OBJ_LIST  = 32'h4000_0000;

  // ----------------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------------
  localparam int unsigned PTYPE_L   = 29;  // parameter type, 3 bits
  localparam int unsigned LTYPE_L   = 24;  // list type, 3 bits
  localparam int unsigned VOLUME_B  = 6;
  localparam int unsigned COLTYPE_L = 4;   // colour type, 2 bits
  localparam int unsigned TEXTURE_B = 3;
  localparam int unsigned OFFSET_B  = 2;
  localparam int unsigned MODE_L    = 0;   // texture/offset/smooth/short_texcoord_flag

  localparam logic [2:0] PTYPE_POLY   = 3'h4;
  localparam logic [2:0] PTYPE_SPRITE = 3'h5;
  localparam logic [2:0] LTYPE_MOD_OP = 3'h1;
  localparam logic [2:0] LTYPE_MOD_TR = 3'h3;
  localparam logic [1:0] COL_INTENS1  = 2'h2;
  localparam logic [1:0] COL_INTENS2  = 2'h3;

  // hidden-surface/shading instruction bits replaced by control word bits
  localparam int unsigned HSS_MODE_L = 22;
  localparam int unsigned MODE_W     = 4;

  // ----------------------------------------------------------------------
  // record classes reported downstream
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CLS_END_LIST,
    CLS_TILE_CLIP,
    CLS_OBJ_LIST,
    CLS_POLY0,
    CLS_POLY1,
    CLS_POLY2,
    CLS_POLY3,
    CLS_POLY4,
    CLS_SPRITE,
    CLS_MOD_VOL,
    CLS_OTHER
  } rec_class_t;

  // alpha, red, green, blue in index order 0..3
  typedef logic [0:3][31:0] argb_t;
  localparam argb_t ARGB_ZERO = '0;

endpackage

// ===== geo_link_if.sv
// geo_link_if: 64-bit valid/ready parameter link between host and decoder.
// Assumes both ends share one clock; a word moves when valid and ready are high.
`timescale 1ns/100ps
`default_nettype none
interface geo_link_if;
  logic [63:0] word;
  logic        valid;
  logic        ready;

  modport host (output word, output valid, input ready);
  modport dev  (input word, input valid, output ready);
endinterface
`default_nettype wire

// ===== geo_param_host.sv
// geo_param_host: packs 32-bit parameter items in pairs onto the 64-bit link.
// Assumes the user offers items in byte offset order, whole records at a time.
`timescale 1ns/100ps
`default_nettype none
module geo_param_host (
  input  wire logic        MCLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        CE_I,
  geo_link_if.host         link,
  input  wire logic [31:0] ITEM_I,
  input  wire logic        ITEM_VALID_I,
  output logic             ITEM_READY_O,
  output logic             HALF_HELD_O
);
  import geo_param_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [31:0] low_r;
  logic        half_r;
  logic [63:0] word_r;
  logic        valid_r;
  logic        item_rdy_r;

  // ----------------------------------------------------------------------
  // handshakes and next values
  // ----------------------------------------------------------------------
  wire logic take_item = ITEM_VALID_I & item_rdy_r;
  wire logic word_done = valid_r & link.ready;
  wire logic pair_done = take_item & half_r;
  // only one word in flight, so item input stalls while the link is busy
  wire logic valid_nxt = pair_done | (valid_r & ~word_done);
  wire logic half_nxt  = take_item ? ~half_r : half_r;
  wire logic [63:0] word_nxt = pair_done ? {ITEM_I, low_r} : word_r;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // odd item waits in low_r until its partner arrives
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      low_r      <= 32'h0000_0000;
      half_r     <= 1'b0;
      word_r     <= 64'h0000_0000_0000_0000;
      valid_r    <= 1'b0;
      item_rdy_r <= 1'b1;
    end else if (CE_I) begin
      if (take_item && !half_r) begin
        low_r <= ITEM_I;
      end
      half_r     <= half_nxt;
      word_r     <= word_nxt;
      valid_r    <= valid_nxt;
      item_rdy_r <= ~valid_nxt;
    end
  end

  // records, sort fields and end markers are items passed straight through
  assign link.word    = word_r;
  assign link.valid   = valid_r;
  assign ITEM_READY_O = item_rdy_r;
  assign HALF_HELD_O  = half_r;

endmodule
`default_nettype wire

// ===== geo_param_decoder.sv
// geo_param_decoder: collects 64-bit parameter words into records and splits
// the control and global records into named fields.
// Assumes one core clock; the host keeps word and item ordering.
//
// Contract
// - parameters arrive as 64-bit link words
// - low half is lower offset, high half next
// - zero control word ends list, rest ignored
// - tile clip takes clip box from 0x10-0x1C
// - object list set: pointer and bounding box
// - type 0: instructions, texture, sort fields
// - type 1: face colour at 0x10-0x1C
// - type 2: face and offset colour, 64 bytes
// - type 3: two shading/texture pairs
// - type 4: two face colours, 64 bytes
// - type 4 face colour feeds base and offset
// - texture control ignored without texturing
// - sort size and next address at 0x18/0x1C
// - control bits 3..0 overwrite instruction bits 25..22
`timescale 1ns/100ps
`default_nettype none
module geo_param_decoder (
  input  wire logic                      MCLK_I,
  input  wire logic                      ARST_N_I,
  input  wire logic                      CE_I,
  geo_link_if.dev                        link,
  output logic                           REC_VALID_O,
  output geo_param_pkg::rec_class_t      REC_CLASS_O,
  output logic [31:0]                    CTRL_WORD_O,
  output logic [31:0]                    HSS_INSTR_O,
  output logic [31:0]                    SHADE0_O,
  output logic [31:0]                    TEXCTL0_O,
  output logic [31:0]                    SHADE1_O,
  output logic [31:0]                    TEXCTL1_O,
  output logic [31:0]                    SORT_SIZE_O,
  output logic [31:0]                    SORT_NEXT_O,
  output logic [31:0]                    OBJ_PTR_O,
  output geo_param_pkg::argb_t           BOX_O,
  output geo_param_pkg::argb_t           BASE0_O,
  output geo_param_pkg::argb_t           OFFS0_O,
  output geo_param_pkg::argb_t           BASE1_O,
  output geo_param_pkg::argb_t           OFFS1_O
);
  import geo_param_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  logic [63:0] rec_mem [REC_WORDS];

  // classify a record by its leading control word
  function automatic rec_class_t classify(input logic [31:0] cw);
    logic [2:0] pt;
    logic [2:0] lt;
    logic [1:0] col;
    logic       vol;
    logic       ofs;
    rec_class_t c;
    pt  = cw[PTYPE_L +: 3];
    lt  = cw[LTYPE_L +: 3];
    col = cw[COLTYPE_L +: 2];
    vol = cw[VOLUME_B];
    ofs = cw[OFFSET_B];
    if (cw == CW_END_LIST) begin
      c = CLS_END_LIST;
    end else if (cw == CW_TILE_CLIP) begin
      c = CLS_TILE_CLIP;
    end else if (cw == CW_OBJ_LIST) begin
      c = CLS_OBJ_LIST;
    end else if (pt == PTYPE_SPRITE) begin
      c = CLS_SPRITE;
    end else if (pt != PTYPE_POLY) begin
      c = CLS_OTHER;
    end else if (lt == LTYPE_MOD_OP || lt == LTYPE_MOD_TR) begin
      c = CLS_MOD_VOL;
    end else if (vol) begin
      c = (col == COL_INTENS1 || col == COL_INTENS2) ? CLS_POLY4 : CLS_POLY3;
    end else if (col == COL_INTENS1 || col == COL_INTENS2) begin
      // mode 2 decodes as type 1, so it carries its own face colour at 0x10-0x1C
      c = (col == COL_INTENS1 && ofs) ? CLS_POLY2 : CLS_POLY1;
    end else begin
      c = CLS_POLY0;
    end
    return c;
  endfunction

  // four consecutive items from byte offset 4*k; items come in as an argument,
  // so a continuous assignment that calls this follows every storage write
  function automatic argb_t quad(input logic [2*REC_WORDS-1:0][31:0] its,
                                 input logic [3:0]                   k);
    argb_t q;
    q[0] = its[k];
    q[1] = its[k + 4'h1];
    q[2] = its[k + 4'h2];
    q[3] = its[k + 4'h3];
    return q;
  endfunction

  // ----------------------------------------------------------------------
  // intake state
  // ----------------------------------------------------------------------
  logic [2:0] beat_r;
  logic [2:0] last_r;
  logic       ready_r;
  logic       emit_r;
  rec_class_t cls_r;

  wire logic       take      = link.valid & ready_r;
  wire logic [31:0] head_cw  = link.word[LO_ITEM_L +: ITEM_W];
  wire rec_class_t head_cls  = classify(head_cw);
  wire logic       head_long = (head_cls == CLS_POLY2) || (head_cls == CLS_POLY4);
  // length is fixed by the first word, before any later word is consumed
  wire logic [2:0] head_last = head_long ? LAST_BEAT_64B : LAST_BEAT_32B;
  wire logic [2:0] cur_last  = (beat_r == 3'h0) ? head_last : last_r;
  wire logic       final_bt  = take && (beat_r == cur_last);
  wire logic [2:0] beat_nxt  = final_bt ? 3'h0 : (take ? beat_r + 3'h1 : beat_r);
  // one idle cycle per record while the fields are latched out
  wire logic       ready_nxt = final_bt ? 1'b0 : (emit_r ? 1'b1 : ready_r);

  // ----------------------------------------------------------------------
  // intake registers
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      beat_r  <= 3'h0;
      last_r  <= LAST_BEAT_32B;
      ready_r <= 1'b1;
      emit_r  <= 1'b0;
      cls_r   <= CLS_END_LIST;
    end else if (CE_I) begin
      if (take && beat_r == 3'h0) begin
        last_r <= head_last;
        cls_r  <= head_cls;
      end
      beat_r  <= beat_nxt;
      ready_r <= ready_nxt;
      emit_r  <= final_bt;
    end
  end

  // record storage is plain data, so it carries no reset
  always_ff @(posedge MCLK_I) begin
    if (CE_I && take) begin
      rec_mem[beat_r] <= link.word;
    end
  end

  assign link.ready = ready_r;

  // ----------------------------------------------------------------------
  // field selection
  // ----------------------------------------------------------------------
  // stored record as items; item j sits at byte offset 4*j, low half first
  wire logic [2*REC_WORDS-1:0][31:0] itm = {rec_mem[7], rec_mem[6], rec_mem[5], rec_mem[4],
                                            rec_mem[3], rec_mem[2], rec_mem[1],
                                            rec_mem[0]};
  wire logic [31:0] cw       = itm[0];
  wire logic        is_poly  = (cls_r inside {CLS_POLY0, CLS_POLY1, CLS_POLY2,
                                              CLS_POLY3, CLS_POLY4});
  wire logic        is_glob  = is_poly || cls_r == CLS_SPRITE || cls_r == CLS_MOD_VOL;
  wire logic        is_box   = (cls_r == CLS_TILE_CLIP) || (cls_r == CLS_OBJ_LIST);
  wire logic        has_sh   = is_glob && cls_r != CLS_MOD_VOL;
  wire logic        two_vol  = (cls_r == CLS_POLY3) || (cls_r == CLS_POLY4);
  wire logic        texture  = cw[TEXTURE_B];
  wire logic [31:0] raw_hss  = itm[1];
  // an end-of-list keeps only its class; every other item is dropped
  wire logic [31:0] ctrl_nxt = (cls_r == CLS_END_LIST) ? CW_END_LIST : cw;
  wire logic [31:0] hss_nxt  = is_glob ? {raw_hss[31:HSS_MODE_L + MODE_W],
                                          cw[MODE_L +: MODE_W],
                                          raw_hss[HSS_MODE_L - 1:0]} : 32'h0000_0000;
  wire logic [31:0] sh0_nxt  = has_sh ? itm[2] : 32'h0000_0000;
  // texture words mean nothing to an untextured polygon, pass zero instead
  wire logic [31:0] tx0_nxt  = (has_sh && texture) ? itm[3] : 32'h0000_0000;
  wire logic [31:0] sh1_nxt  = two_vol ? itm[4] : 32'h0000_0000;
  wire logic [31:0] tx1_nxt  = (two_vol && texture) ? itm[5] : 32'h0000_0000;
  wire logic        has_sort = has_sh && cls_r != CLS_POLY1;
  wire logic [31:0] ssz_nxt  = has_sort ? itm[6] : 32'h0000_0000;
  wire logic [31:0] snx_nxt  = has_sort ? itm[7] : 32'h0000_0000;
  wire logic [31:0] ptr_nxt  = (cls_r == CLS_OBJ_LIST) ? itm[1] : 32'h0000_0000;
  // clip box and bounding box share the same four item slots
  wire argb_t       box_nxt  = is_box ? quad(itm, 4'h4) : ARGB_ZERO;
  wire argb_t       face0    = quad(itm, 4'h8);
  wire argb_t       face1    = quad(itm, 4'hC);
  wire argb_t       sprite_b = {itm[4], 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  wire argb_t       sprite_o = {itm[5], 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  // face colours by polygon type; sprite colours stay packed in slot 0
  wire argb_t base0_nxt = (cls_r == CLS_POLY1) ? quad(itm, 4'h4) :
                          (cls_r == CLS_POLY2) ? face0 :
                          (cls_r == CLS_POLY4) ? face0 :
                          (cls_r == CLS_SPRITE) ? sprite_b : ARGB_ZERO;
  wire argb_t offs0_nxt = (cls_r == CLS_POLY2) ? face1 :
                          (cls_r == CLS_POLY4) ? face0 :
                          (cls_r == CLS_SPRITE) ? sprite_o : ARGB_ZERO;
  wire argb_t base1_nxt = (cls_r == CLS_POLY4) ? face1 : ARGB_ZERO;
  wire argb_t offs1_nxt = (cls_r == CLS_POLY4) ? face1 : ARGB_ZERO;

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  // fields hold until the next record is emitted
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REC_VALID_O <= 1'b0;
      REC_CLASS_O <= CLS_END_LIST;
      CTRL_WORD_O <= 32'h0000_0000;
      HSS_INSTR_O <= 32'h0000_0000;
      SHADE0_O    <= 32'h0000_0000;
      TEXCTL0_O   <= 32'h0000_0000;
      SHADE1_O    <= 32'h0000_0000;
      TEXCTL1_O   <= 32'h0000_0000;
      SORT_SIZE_O <= 32'h0000_0000;
      SORT_NEXT_O <= 32'h0000_0000;
      OBJ_PTR_O   <= 32'h0000_0000;
      BOX_O       <= ARGB_ZERO;
      BASE0_O     <= ARGB_ZERO;
      OFFS0_O     <= ARGB_ZERO;
      BASE1_O     <= ARGB_ZERO;
      OFFS1_O     <= ARGB_ZERO;
    end else if (CE_I) begin
      REC_VALID_O <= emit_r;
      if (emit_r) begin
        REC_CLASS_O <= cls_r;
        CTRL_WORD_O <= ctrl_nxt;
        HSS_INSTR_O <= hss_nxt;
        SHADE0_O    <= sh0_nxt;
        TEXCTL0_O   <= tx0_nxt;
        SHADE1_O    <= sh1_nxt;
        TEXCTL1_O   <= tx1_nxt;
        SORT_SIZE_O <= ssz_nxt;
        SORT_NEXT_O <= snx_nxt;
        OBJ_PTR_O   <= ptr_nxt;
        BOX_O       <= box_nxt;
        BASE0_O     <= base0_nxt;
        OFFS0_O     <= offs0_nxt;
        BASE1_O     <= base1_nxt;
        OFFS1_O     <= offs1_nxt;
      end
    end
  end

endmodule
`default_nettype wire

// ===== geo_link_checker.sv
// geo_link_checker: timing checks on the 64-bit link between both ends.
// Assumes it sits beside the link interface; clock enable drops only while idle.
`timescale 1ns/100ps
`default_nettype none
module geo_link_checker (
  input  wire logic        MCLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic [63:0] word,
  input  wire logic        valid,
  input  wire logic        ready
);
  import geo_param_pkg::*;

  // ----------------------------------------------------------------------
  // helper: beats of the current record and its expected length
  // ----------------------------------------------------------------------
  logic [3:0]  beats_r;
  logic        long_r;
  logic [31:0] cw;
  logic        mod_vol;
  logic        long_rec;

  // length guessed from the leading word only, as the decoder must
  assign cw       = word[31:0];
  assign mod_vol  = (cw[26:24] == LTYPE_MOD_OP) || (cw[26:24] == LTYPE_MOD_TR);
  assign long_rec = (cw[31:29] == PTYPE_POLY) && !mod_vol &&
                    (cw[VOLUME_B] ? (cw[5:4] == COL_INTENS1 || cw[5:4] == COL_INTENS2)
                                  : (cw[5:4] == COL_INTENS1 && cw[OFFSET_B]));

  // counter clears in the ready gap, so it never spans two records
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      beats_r <= 4'h0;
      long_r  <= 1'b0;
    end else if (!ready) begin
      beats_r <= 4'h0;
    end else if (valid) begin
      beats_r <= beats_r + 4'h1;
      if (beats_r == 4'h0) begin
        long_r <= long_rec;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  word_hold_a: assert property (valid && !ready |=> valid && $stable(word))
    else $error("link word changed before it was taken");
  reset_idle_a: assert property ($rose(ARST_N_I) |-> ready && !valid)
    else $error("link not idle after reset");
  pair_gap_a: assert property (valid && ready |=> !valid [*2])
    else $error("link word sent without two new items");
  short_gap_a: assert property (!ready |=> ready)
    else $error("ready low for more than one cycle");
  gap_cause_a: assert property (!ready |-> $past(valid && ready))
    else $error("ready dropped without a taken word");
  short_len_a: assert property ($fell(ready) && !long_r |-> beats_r == 4'h4)
    else $error("32-byte record not four words");
  long_len_a: assert property ($fell(ready) && long_r |-> beats_r == 4'h8)
    else $error("64-byte record not eight words");
  end_gap_a: assert property ((beats_r == 4'h8) || (beats_r == 4'h4 && !long_r) |-> !ready)
    else $error("no ready gap after final word");
endmodule
`default_nettype wire

// ===== tb.sv
// tb: sends whole records into the host end and checks decoded fields.
// Assumes the host and decoder meet directly through one link interface.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import geo_param_pkg::*;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        mclk;
  logic        arst_n;
  logic        ce;
  logic [31:0] item;
  logic        item_valid;
  logic        item_ready;
  logic        half_held;
  logic        rec_valid;
  rec_class_t  rec_class;
  logic [31:0] ctrl_word, hss, shade0, texctl0, shade1, texctl1;
  logic [31:0] sort_size, sort_next, obj_ptr;
  argb_t       box, base0, offs0, base1, offs1;
  logic [31:0] ex [16];
  int          wi;
  int          err_total;
  int          samples_checked;

  geo_link_if lnk ();
  geo_param_host i_geo_param_host (.MCLK_I(mclk), .ARST_N_I(arst_n), .CE_I(ce), .link(lnk),
    .ITEM_I(item), .ITEM_VALID_I(item_valid), .ITEM_READY_O(item_ready),
    .HALF_HELD_O(half_held));
  geo_param_decoder i_geo_param_decoder (.MCLK_I(mclk), .ARST_N_I(arst_n), .CE_I(ce),
    .link(lnk), .REC_VALID_O(rec_valid), .REC_CLASS_O(rec_class), .CTRL_WORD_O(ctrl_word),
    .HSS_INSTR_O(hss), .SHADE0_O(shade0), .TEXCTL0_O(texctl0), .SHADE1_O(shade1),
    .TEXCTL1_O(texctl1), .SORT_SIZE_O(sort_size), .SORT_NEXT_O(sort_next),
    .OBJ_PTR_O(obj_ptr), .BOX_O(box), .BASE0_O(base0), .OFFS0_O(offs0), .BASE1_O(base1),
    .OFFS1_O(offs1));
  geo_link_checker i_geo_link_checker (.MCLK_I(mclk), .ARST_N_I(arst_n), .word(lnk.word),
    .valid(lnk.valid), .ready(lnk.ready));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // distinct item per offset, so a swapped field shows up
  function automatic logic [31:0] it(input int k);
    return {16'hC0DE, 8'(k), ~8'(k)};
  endfunction

  function automatic logic [31:0] hx(input logic [31:0] cw);
    logic [31:0] v;
    v = it(1);
    v[25:22] = cw[3:0];
    return v;
  endfunction

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // items go in back to back; the host stalls us after each pair
  task automatic send_rec(input logic [31:0] cw, input int n);
    int t;
    for (int k = 0; k < 16; k++) ex[k] = (k == 0) ? cw : it(k);
    wi = 0;
    @(posedge mclk);
    for (int k = 0; k < n; k++) begin
      #1;
      if (k > 0) chk(half_held, k % 2);
      item = ex[k];
      item_valid = 1'b1;
      t = 0;
      do begin
        @(posedge mclk);
        t++;
      end while (item_ready !== 1'b1 && t < 50);
      if (t >= 50) begin
        err_total++;
        summarize();
      end
    end
    #1;
    item_valid = 1'b0;
    t = 0;
    while (rec_valid !== 1'b1 && t < 50) begin
      @(posedge mclk);
      #1;
      t++;
    end
    if (t >= 50) begin
      err_total++;
      summarize();
    end
  endtask

  // every link word must pair the two items of its offsets
  always @(posedge mclk) begin
    if (lnk.valid === 1'b1 && lnk.ready === 1'b1) begin
      chk(lnk.word, {ex[2*wi+1], ex[2*wi]});
      wi++;
    end
  end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_clip();
    send_rec(CW_TILE_CLIP, 8);
    chk(rec_class, CLS_TILE_CLIP);
    chk(ctrl_word, CW_TILE_CLIP);
    chk(box, {it(4), it(5), it(6), it(7)});
    chk(obj_ptr, 0);
  endtask

  // a frozen host must neither take an offered item nor raise the link
  task automatic t_freeze();
    @(posedge mclk);
    #1;
    ce = 1'b0;
    item = it(0);
    item_valid = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk({half_held, item_ready, lnk.valid}, 3'b010);
    ce = 1'b1;
    item_valid = 1'b0;
  endtask

  task automatic t_obj();
    send_rec(CW_OBJ_LIST, 8);
    chk(rec_class, CLS_OBJ_LIST);
    chk(obj_ptr, it(1));
    chk(box, {it(4), it(5), it(6), it(7)});
  endtask

  // follows a record with fields, so cleared outputs prove the decode
  task automatic t_end();
    send_rec(CW_END_LIST, 8);
    chk(rec_class, CLS_END_LIST);
    chk(box, 0);
    chk(obj_ptr, 0);
  endtask

  task automatic t_poly0();
    send_rec(32'h8000_0008, 8);
    chk(rec_class, CLS_POLY0);
    chk(hss, hx(32'h8000_0008));
    chk({shade0, texctl0}, {it(2), it(3)});
    chk({sort_size, sort_next}, {it(6), it(7)});
  endtask

  task automatic t_notex();
    send_rec(32'h8000_0003, 8);
    chk(texctl0, 0);
    chk(hss, hx(32'h8000_0003));
  endtask

  task automatic t_poly1();
    send_rec(32'h8000_002A, 8);
    chk(rec_class, CLS_POLY1);
    chk(base0, {it(4), it(5), it(6), it(7)});
    chk(sort_size, 0);
  endtask

  task automatic t_poly2();
    send_rec(32'h8000_002C, 16);
    chk(rec_class, CLS_POLY2);
    chk(base0, {it(8), it(9), it(10), it(11)});
    chk(offs0, {it(12), it(13), it(14), it(15)});
    chk(sort_next, it(7));
  endtask

  task automatic t_poly3();
    send_rec(32'h8000_0048, 8);
    chk(rec_class, CLS_POLY3);
    chk({shade0, texctl0, shade1, texctl1}, {it(2), it(3), it(4), it(5)});
  endtask

  task automatic t_poly4();
    send_rec(32'h8000_0068, 16);
    chk(rec_class, CLS_POLY4);
    chk(base0, {it(8), it(9), it(10), it(11)});
    chk(base1, {it(12), it(13), it(14), it(15)});
    chk(offs0, {it(8), it(9), it(10), it(11)});
    chk(offs1, {it(12), it(13), it(14), it(15)});
  endtask

  task automatic t_other();
    send_rec(32'h8300_0008, 8);
    chk(rec_class, CLS_MOD_VOL);
    chk({sort_size, texctl0}, 0);
    send_rec(32'hA000_0009, 8);
    chk(rec_class, CLS_SPRITE);
    chk({sort_size, sort_next}, {it(6), it(7)});
    // unknown parameter type: still a 32-byte record, only class and control word
    send_rec(32'hE000_0000, 8);
    chk(rec_class, CLS_OTHER);
    chk({ctrl_word, hss, sort_size}, {32'hE000_0000, 64'h0});
  endtask

  // ----------------------------------------------------------------------
  // clock, reset and sequence
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    item = '0;
    item_valid = 1'b0;
    err_total = 0;
    samples_checked = 0;
    wi = 0;
    repeat (16) @(posedge mclk);
    #1 arst_n = 1'b1;
    t_clip();
    t_freeze();
    t_obj();
    t_end();
    t_poly0();
    t_notex();
    t_poly1();
    t_poly2();
    t_poly3();
    t_poly4();
    t_other();
    summarize();
  end
endmodule
`default_nettype wire
